//--- tdc_pkg.sv
// Shared constants and carrier types for the transducer diagnostic and command port
package tdc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] DIAG_BASE_ADDR = 12'h000;    // First channel segment
  localparam int unsigned DIAG_WORD_STRIDE = 2;         // Segment step in 16-bit words
  localparam int unsigned HALFWORD_BYTES = 2;           // Bytes per 16-bit word
  localparam logic [11:0] CMD_OUT_ADDR = 12'h100;       // Command output area, six words
  localparam logic [11:0] CMD_CODE_ADDR = 12'h100;      // command_code
  localparam logic [11:0] CMD_TARGET_ADDR = 12'h104;    // target_channel_select
  localparam logic [11:0] CMD_OUT_LAST = 12'h114;       // Last word of output area
  localparam logic [11:0] CMD_IN_ADDR = 12'h120;        // command_response_code
  localparam logic [11:0] CMD_IN_LAST = 12'h134;        // Last word of input area
  localparam logic [11:0] ENABLE_ADDR = 12'h140;        // Alarm and diagnostic enables
  localparam logic [11:0] SCAN_DONE_ADDR = 12'h144;     // Write strobe: CPU I/O scan done
  localparam logic [7:0] ENABLE_RESET = 8'h00;          // All features disabled

  // ----------------------------------------------------------------
  // Enable register bit positions
  // ----------------------------------------------------------------
  localparam int unsigned EN_LOW = 0;
  localparam int unsigned EN_HIGH = 1;
  localparam int unsigned EN_OPEN_WIRE = 2;
  localparam int unsigned EN_NEW_DATA = 3;
  localparam int unsigned EN_ERR_RESP = 4;
  localparam int unsigned EN_BIT_FAIL = 5;
  localparam int unsigned EN_IIC_FAIL = 6;
  localparam int unsigned EN_THIRD_FAIL = 7;

  // ----------------------------------------------------------------
  // Channel flag bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_LOW = 0;
  localparam int unsigned FLAG_HIGH = 1;
  localparam int unsigned FLAG_COMM_LOSS = 4;
  localparam int unsigned FLAG_NEW_DATA = 23;
  localparam int unsigned FLAG_ERR_RESP = 24;
  localparam int unsigned FLAG_BIT_FAIL = 28;
  localparam int unsigned FLAG_IIC_FAIL = 29;
  localparam int unsigned FLAG_THIRD_FAIL = 30;
  localparam int unsigned FLAG_BITS = 32;

  // ----------------------------------------------------------------
  // Command and response codes
  // ----------------------------------------------------------------
  localparam logic [31:0] CMD_NONE = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET = 32'h0000_0001;
  localparam logic [31:0] RSP_IDLE = 32'h0000_0000;
  localparam logic [31:0] RSP_PROCESSING = 32'h0000_0001;
  localparam logic [31:0] RSP_COMPLETE = 32'h0000_0002;
  localparam logic [31:0] RSP_TIMEOUT = 32'h1111_1111;
  localparam logic [31:0] RSP_REPLY_ERR = 32'h1111_1110;
  localparam logic [31:0] RSP_BIT_FAIL = 32'h1111_1101;
  localparam logic [31:0] RSP_IIC_FAIL = 32'h1111_1100;
  localparam logic [31:0] RSP_ORDER_ERR = 32'h1111_0111;
  localparam logic [3:0] GLOBAL_ADDR = 4'hF;            // Reset to all transducers

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REPLY_COMPLETE = 3'b000,
    REPLY_TIMEOUT = 3'b001,
    REPLY_ERROR = 3'b010,
    REPLY_BIT_FAIL = 3'b011,
    REPLY_IIC_FAIL = 3'b100
  } tdc_reply_kind_t;

  // One pressure read attempt result
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic ok;
    logic noResp;
    logic [2:0] respStatus;
    logic lowAlarm;
    logic highAlarm;
  } tdc_read_t;

  // Latched fault indications read back from a transducer
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic bitFail;
    logic invalidInputConditionFailure;
    logic thirdTransducerFailure;
  } tdc_fault_t;

  // Reply to a reset command
  typedef struct packed {
    logic valid;
    tdc_reply_kind_t kind;
  } tdc_reply_t;

endpackage

//--- tdc_diag_cmd_port.sv
// Diagnostic flag words and command handshake for a serial transducer interface
`timescale 1ns/1ps
`default_nettype none
// Function
// - Each channel owns a 32-bit diagnostic segment
// - Segment address steps two words per channel
// - Bit 0 follows low alarm while enabled
// - Bit 1 follows high alarm while enabled
// - Bit 4 sets on no response, scan clears
// - Bit 4 also set by faults 28-30
// - Bit 23 sets on good read, scan clears
// - Bit 24 set when reply status shows error
// - Bits 28-30 latch faults, scan clears
// - Response shows processing while command runs
// - Command field: zero none, one reset
// - Address field bits 0-3 select channel
// - Reset goes to selected channel, no error
// - Reset to address 15 resets all
// - Transducer reply status lands in response field
// - Codes for complete, timeout, reply error
// - Codes for BIT, invalid input, order error
// - Disabled features set no new flags; bits 0-1 drop at once
module tdc_diag_cmd_port #(
  parameter int unsigned NUM_CH = 15
) (
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transducer side
  input wire tdc_pkg::tdc_read_t readResult,
  input wire tdc_pkg::tdc_fault_t faultResult,
  input wire tdc_pkg::tdc_reply_t cmdReply,
  output logic xdcrResetReq,
  output logic [3:0] xdcrResetChan,
  output logic xdcrResetAll
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Address 15 is the global reset, so at most fifteen real channels
  if (NUM_CH < 1 || NUM_CH > 15) begin : gBadNumCh
    $error("NUM_CH must lie in 1..15");
  end

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_BUSY = 2'b01,
    CMD_DONE = 2'b10
  } tdc_cmd_state_t;

  logic [tdc_pkg::FLAG_BITS-1:0] flags_r [NUM_CH];   // Channel segments
  logic [tdc_pkg::FLAG_BITS-1:0] flags_nxt [NUM_CH];
  logic [31:0] cmdCode_r;                            // command_code
  logic [31:0] target_r;                             // target_channel_select
  logic [31:0] response_r;                           // command_response_code
  logic [7:0] enable_r;                              // Feature enables
  tdc_cmd_state_t cmdState_r;                        // Handshake state
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic xdcrResetReq_r;
  logic [3:0] xdcrResetChan_r;
  logic xdcrResetAll_r;

  // Bus phase decode
  logic accessStart;                                 // First access cycle
  logic wrTake;                                      // Write commits this edge
  logic scanDone;                                    // CPU I/O scan complete strobe
  logic cmdWrite;                                    // Write to command_code
  logic [31:0] rdWord;                               // Read mux result
  logic rdHit;                                       // Address is mapped

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte address of a channel segment: base plus two 16-bit words per channel
  function automatic logic [11:0] segAddr(input int unsigned ch);
    segAddr = tdc_pkg::DIAG_BASE_ADDR +
      12'(ch * tdc_pkg::DIAG_WORD_STRIDE * tdc_pkg::HALFWORD_BYTES);
  endfunction

  // Map a transducer reply onto the response code
  function automatic logic [31:0] replyCode(input tdc_pkg::tdc_reply_kind_t k);
    case (k)
      tdc_pkg::REPLY_COMPLETE: replyCode = tdc_pkg::RSP_COMPLETE;
      tdc_pkg::REPLY_TIMEOUT: replyCode = tdc_pkg::RSP_TIMEOUT;
      tdc_pkg::REPLY_ERROR: replyCode = tdc_pkg::RSP_REPLY_ERR;
      tdc_pkg::REPLY_BIT_FAIL: replyCode = tdc_pkg::RSP_BIT_FAIL;
      tdc_pkg::REPLY_IIC_FAIL: replyCode = tdc_pkg::RSP_IIC_FAIL;
      default: replyCode = tdc_pkg::RSP_REPLY_ERR;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign accessStart = psel && penable && !pready_r;
  assign wrTake = psel && penable && pready_r && pwrite;
  assign scanDone = wrTake && (paddr == tdc_pkg::SCAN_DONE_ADDR);
  assign cmdWrite = wrTake && (paddr == tdc_pkg::CMD_CODE_ADDR);

  // Read mux; unmapped addresses flag an error
  always_comb begin
    rdWord = 32'h0000_0000;
    rdHit = 1'b0;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (paddr == segAddr(c)) begin
        rdWord = flags_r[c];
        rdHit = 1'b1;
      end
    end
    if (paddr == tdc_pkg::CMD_CODE_ADDR) begin
      rdWord = cmdCode_r;
      rdHit = 1'b1;
    end else if (paddr == tdc_pkg::CMD_TARGET_ADDR) begin
      rdWord = target_r;
      rdHit = 1'b1;
    end else if (paddr >= tdc_pkg::CMD_OUT_ADDR && paddr <= tdc_pkg::CMD_OUT_LAST && paddr[1:0] == 2'b00) begin
      rdHit = 1'b1;                                  // Reserved output words read zero
    end else if (paddr == tdc_pkg::CMD_IN_ADDR) begin
      rdWord = response_r;
      rdHit = 1'b1;
    end else if (paddr >= tdc_pkg::CMD_IN_ADDR && paddr <= tdc_pkg::CMD_IN_LAST && paddr[1:0] == 2'b00) begin
      rdHit = 1'b1;                                  // Reserved input words read zero
    end else if (paddr == tdc_pkg::ENABLE_ADDR) begin
      rdWord = {24'h00_0000, enable_r};
      rdHit = 1'b1;
    end else if (paddr == tdc_pkg::SCAN_DONE_ADDR) begin
      rdHit = 1'b1;                                  // Strobe register reads zero
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait cycle, data and error registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= accessStart;
      if (accessStart) begin
        // Read data captured for the answering cycle
        prdata_r <= pwrite ? 32'h0000_0000 : rdWord;
        pslverr_r <= !rdHit;
      end else begin
        prdata_r <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmdCode_r <= tdc_pkg::CMD_NONE;
      target_r <= 32'h0000_0000;
      enable_r <= tdc_pkg::ENABLE_RESET;
    end else if (wrTake) begin
      if (paddr == tdc_pkg::CMD_CODE_ADDR) begin
        cmdCode_r <= pwdata;
      end
      if (paddr == tdc_pkg::CMD_TARGET_ADDR) begin
        target_r <= pwdata;
      end
      if (paddr == tdc_pkg::ENABLE_ADDR) begin
        enable_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command handshake and reset issue
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmdState_r <= CMD_IDLE;
      response_r <= tdc_pkg::RSP_IDLE;
      xdcrResetReq_r <= 1'b0;
      xdcrResetChan_r <= 4'h0;
      xdcrResetAll_r <= 1'b0;
    end else begin
      xdcrResetReq_r <= 1'b0;
      case (cmdState_r)
        CMD_IDLE: begin
          if (cmdWrite && pwdata == tdc_pkg::CMD_RESET) begin
            // Issue reset to the selected channel, 15 meaning all
            xdcrResetReq_r <= 1'b1;
            xdcrResetChan_r <= target_r[3:0];
            xdcrResetAll_r <= (target_r[3:0] == tdc_pkg::GLOBAL_ADDR);
            response_r <= tdc_pkg::RSP_PROCESSING;
            cmdState_r <= CMD_BUSY;
          end
        end
        CMD_BUSY: begin
          if (cmdWrite && pwdata != tdc_pkg::CMD_NONE) begin
            // New command before the idle handshake
            response_r <= tdc_pkg::RSP_ORDER_ERR;
            cmdState_r <= CMD_DONE;
          end else if (cmdReply.valid) begin
            response_r <= replyCode(cmdReply.kind);
            cmdState_r <= CMD_DONE;
          end
        end
        CMD_DONE: begin
          if (cmdWrite && pwdata != tdc_pkg::CMD_NONE) begin
            response_r <= tdc_pkg::RSP_ORDER_ERR;
          end else if (cmdCode_r == tdc_pkg::CMD_NONE && !cmdWrite) begin
            // Application cleared the command: back to idle
            response_r <= tdc_pkg::RSP_IDLE;
            cmdState_r <= CMD_IDLE;
          end
        end
        default: begin
          cmdState_r <= CMD_IDLE;
          response_r <= tdc_pkg::RSP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel flag next values
  // ----------------------------------------------------------------
  // Set wins over the scan-done clear when both land in one cycle
  always_comb begin
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      flags_nxt[c] = flags_r[c];
      // Scan completion clears the event flags
      if (scanDone) begin
        flags_nxt[c][tdc_pkg::FLAG_COMM_LOSS] = 1'b0;
        flags_nxt[c][tdc_pkg::FLAG_NEW_DATA] = 1'b0;
        flags_nxt[c][tdc_pkg::FLAG_BIT_FAIL] = 1'b0;
        flags_nxt[c][tdc_pkg::FLAG_IIC_FAIL] = 1'b0;
        flags_nxt[c][tdc_pkg::FLAG_THIRD_FAIL] = 1'b0;
      end
      // Pressure read attempt for this channel
      if (readResult.valid && readResult.chan == 4'(c)) begin
        flags_nxt[c][tdc_pkg::FLAG_LOW] = readResult.lowAlarm;
        flags_nxt[c][tdc_pkg::FLAG_HIGH] = readResult.highAlarm;
        if (readResult.noResp && enable_r[tdc_pkg::EN_OPEN_WIRE]) begin
          flags_nxt[c][tdc_pkg::FLAG_COMM_LOSS] = 1'b1;
        end
        if (readResult.ok && enable_r[tdc_pkg::EN_NEW_DATA]) begin
          flags_nxt[c][tdc_pkg::FLAG_NEW_DATA] = 1'b1;
        end
        if (!readResult.noResp) begin
          // Tracks the most recent reply status
          flags_nxt[c][tdc_pkg::FLAG_ERR_RESP] =
            enable_r[tdc_pkg::EN_ERR_RESP] && (readResult.respStatus != 3'h0);
        end
      end
      // Latched faults read after download or reset
      if (faultResult.valid && faultResult.chan == 4'(c)) begin
        if (faultResult.bitFail && enable_r[tdc_pkg::EN_BIT_FAIL]) begin
          flags_nxt[c][tdc_pkg::FLAG_BIT_FAIL] = 1'b1;
        end
        if (faultResult.invalidInputConditionFailure && enable_r[tdc_pkg::EN_IIC_FAIL]) begin
          flags_nxt[c][tdc_pkg::FLAG_IIC_FAIL] = 1'b1;
        end
        if (faultResult.thirdTransducerFailure && enable_r[tdc_pkg::EN_THIRD_FAIL]) begin
          flags_nxt[c][tdc_pkg::FLAG_THIRD_FAIL] = 1'b1;
        end
      end
      // Any latched fault forces communication loss
      if (flags_nxt[c][tdc_pkg::FLAG_BIT_FAIL] || flags_nxt[c][tdc_pkg::FLAG_IIC_FAIL] ||
          flags_nxt[c][tdc_pkg::FLAG_THIRD_FAIL]) begin
        flags_nxt[c][tdc_pkg::FLAG_COMM_LOSS] = 1'b1;
      end
      // Disabled low and high alarm bits are dropped at once
      if (!enable_r[tdc_pkg::EN_LOW]) begin
        flags_nxt[c][tdc_pkg::FLAG_LOW] = 1'b0;
      end
      if (!enable_r[tdc_pkg::EN_HIGH]) begin
        flags_nxt[c][tdc_pkg::FLAG_HIGH] = 1'b0;
      end
      // Reserved bits held at zero
      flags_nxt[c][3:2] = 2'b00;
      flags_nxt[c][22:5] = 18'h0_0000;
      flags_nxt[c][27:25] = 3'b000;
      flags_nxt[c][31] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Channel flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (reset) begin
        flags_r[c] <= 32'h0000_0000;
      end else begin
        flags_r[c] <= flags_nxt[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign xdcrResetReq = xdcrResetReq_r;
  assign xdcrResetChan = xdcrResetChan_r;
  assign xdcrResetAll = xdcrResetAll_r;

endmodule
`default_nettype wire

//--- tdc_port_props.sv
// Concurrent checks on the port pins of the diagnostic and command port
`timescale 1ns/1ps
`default_nettype none
module tdc_port_props #(
  parameter int unsigned NUM_CH = 15
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xdcrResetReq,
  input wire logic [3:0] xdcrResetChan,
  input wire logic xdcrResetAll
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic resetWr; // Committing write of the reset code
  logic segRead; // Read of a channel segment completing
  assign resetWr = psel && penable && pready && pwrite && paddr == tdc_pkg::CMD_CODE_ADDR && pwdata == tdc_pkg::CMD_RESET;
  assign segRead = psel && penable && pready && !pwrite && paddr < 12'(NUM_CH * 4);
  sequence setupSeq;
    psel && !penable;
  endsequence
  sequence answerSeq;
    ##2 pready ##1 !pready;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  apb_answer_a: assert property (setupSeq |-> answerSeq) else $error("access not answered in two cycles");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("error flag without ready");
  reset_cause_a: assert property (xdcrResetReq |-> $past(resetWr)) else $error("reset sent without command write");
  reset_pulse_a: assert property (xdcrResetReq |=> !xdcrResetReq) else $error("reset request longer than one cycle");
  global_flag_a: assert property (xdcrResetReq |-> xdcrResetAll == (xdcrResetChan == tdc_pkg::GLOBAL_ADDR)) else $error("global reset flag wrong");
  chan_hold_a: assert property (!xdcrResetReq |-> $stable(xdcrResetChan)) else $error("reset channel moved");
  reserved_zero_a: assert property (segRead |-> prdata[3:2] == 2'h0 && prdata[22:5] == 18'h0 && !prdata[31]) else $error("reserved flag set");
  comm_loss_fault_a: assert property (segRead && |prdata[30:28] |-> prdata[4]) else $error("fault without comm loss flag");
endmodule
bind tdc_diag_cmd_port tdc_port_props #(.NUM_CH(NUM_CH)) i_props (.sys_clk(sys_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .xdcrResetReq(xdcrResetReq), .xdcrResetChan(xdcrResetChan), .xdcrResetAll(xdcrResetAll));
`default_nettype wire

//--- tdc_xdcr_model.sv
// Behavioural transducer network answering reset commands
`timescale 1ns/1ps
`default_nettype none
module tdc_xdcr_model #(
  parameter int unsigned REPLY_DLY = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic xdcrResetReq,
  input wire logic [3:0] xdcrResetChan,
  input wire tdc_pkg::tdc_reply_kind_t replyKind,
  input wire logic [2:0] faults,
  output var tdc_pkg::tdc_reply_t cmdReply,
  output var tdc_pkg::tdc_fault_t faultResult
);
  logic busy_r; // Reset command in flight
  int cnt_r; // Cycles left before the reply
  // Reply after a delay; faults are reported with the reply only when any fault bit is set
  always_ff @(posedge sys_clk) begin
    cmdReply <= '0;
    faultResult <= '0;
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 0;
    end else if (xdcrResetReq) begin
      busy_r <= 1'b1;
      cnt_r <= REPLY_DLY;
    end else if (busy_r && cnt_r == 0) begin
      busy_r <= 1'b0;
      cmdReply <= {1'b1, replyKind};
      faultResult <= {|faults, xdcrResetChan, faults};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule
`default_nettype wire

//--- test_transducer_diag_command_port.sv
// Self-checking bench for the diagnostic and command port
`timescale 1ns/1ps
`default_nettype none
module test_transducer_diag_command_port;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, xdcrResetReq, xdcrResetAll, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [3:0] xdcrResetChan;
  logic [2:0] faults = 3'h0; // Fault bits the transducers report
  tdc_pkg::tdc_read_t readResult = '0;
  tdc_pkg::tdc_fault_t faultResult;
  tdc_pkg::tdc_reply_t cmdReply;
  tdc_pkg::tdc_reply_kind_t replyKind = tdc_pkg::REPLY_COMPLETE;
  int n_fail = 0, n_tests = 0, cyc = 0, nReq = 0, k;
  logic [31:0] expRsp [5] = '{tdc_pkg::RSP_COMPLETE, tdc_pkg::RSP_TIMEOUT, tdc_pkg::RSP_REPLY_ERR,
    tdc_pkg::RSP_BIT_FAIL, tdc_pkg::RSP_IIC_FAIL};
  always #50 sys_clk = ~sys_clk;
  tdc_diag_cmd_port i_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .readResult(readResult),
    .faultResult(faultResult), .cmdReply(cmdReply), .xdcrResetReq(xdcrResetReq), .xdcrResetChan(xdcrResetChan),
    .xdcrResetAll(xdcrResetAll));
  tdc_xdcr_model i_xdcr (.sys_clk(sys_clk), .reset(reset), .xdcrResetReq(xdcrResetReq),
    .xdcrResetChan(xdcrResetChan), .replyKind(replyKind), .faults(faults), .cmdReply(cmdReply),
    .faultResult(faultResult));
  // Count reset requests and cut a hang short
  always @(posedge sys_clk) begin
    if (xdcrResetReq === 1'b1) nReq++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask
  // Poll the response until it equals (or leaves) a value
  task waitRsp(input logic [31:0] v, input bit same);
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, tdc_pkg::CMD_IN_ADDR, 32'h0000_0000);
      if ((r === v) == same) break;
    end
  endtask
  task pulse(input tdc_pkg::tdc_read_t v);
    readResult <= v;
    @(posedge sys_clk);
    readResult <= '0;
    @(posedge sys_clk);
  endtask
  // Full reset command handshake with the expected final code
  task cmd(input logic [3:0] ch, input logic [31:0] exp);
    wr(tdc_pkg::CMD_TARGET_ADDR, {28'h0, ch});
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_RESET);
    rc(tdc_pkg::CMD_IN_ADDR, tdc_pkg::RSP_PROCESSING);
    waitRsp(tdc_pkg::RSP_PROCESSING, 1'b0);
    chk(r, exp);
    chk({27'h0, xdcrResetAll, xdcrResetChan}, {27'h0, ch == 4'hF, ch});
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_NONE);
    waitRsp(tdc_pkg::RSP_IDLE, 1'b1);
    chk(r, tdc_pkg::RSP_IDLE);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rc(tdc_pkg::ENABLE_ADDR, {24'h0, tdc_pkg::ENABLE_RESET});
    rc(tdc_pkg::CMD_IN_ADDR, tdc_pkg::RSP_IDLE);
    wr(tdc_pkg::ENABLE_ADDR, 32'h0000_00FF);
    pulse({1'b1, 4'h3, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0});
    rc(12'h00C, 32'h0080_0001);
    pulse({1'b1, 4'h3, 1'b1, 1'b0, 3'h0, 1'b0, 1'b1});
    rc(12'h00C, 32'h0080_0002);
    pulse({1'b1, 4'hE, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0});
    rc(12'h038, 32'h0000_0010);
    pulse({1'b1, 4'h5, 1'b1, 1'b0, 3'h2, 1'b0, 1'b0});
    rc(12'h014, 32'h0180_0000);
    wr(tdc_pkg::SCAN_DONE_ADDR, 32'h0000_0000);
    rc(12'h038, 32'h0000_0000);
    rc(12'h014, 32'h0100_0000);
    rc(12'h00C, 32'h0000_0002);
    wr(tdc_pkg::ENABLE_ADDR, 32'h0000_0000);
    pulse({1'b1, 4'h3, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1});
    rc(12'h00C, 32'h0000_0000);
    wr(tdc_pkg::ENABLE_ADDR, 32'h0000_00FF);
    for (int i = 0; i < 5; i++) begin
      replyKind <= tdc_pkg::tdc_reply_kind_t'(i);
      cmd(4'(i * 3), expRsp[i]);
    end
    replyKind <= tdc_pkg::REPLY_COMPLETE;
    cmd(4'hF, tdc_pkg::RSP_COMPLETE);
    faults <= 3'h7;
    cmd(4'h7, tdc_pkg::RSP_COMPLETE);
    faults <= 3'h0;
    rc(12'h01C, 32'h7000_0010);
    wr(tdc_pkg::SCAN_DONE_ADDR, 32'h0000_0000);
    rc(12'h01C, 32'h0000_0000);
    k = nReq;
    wr(tdc_pkg::CMD_TARGET_ADDR, 32'h0000_0001);
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_RESET);
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_RESET);
    rc(tdc_pkg::CMD_IN_ADDR, tdc_pkg::RSP_ORDER_ERR);
    chk(32'(nReq - k), 32'h0000_0001);
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_NONE);
    waitRsp(tdc_pkg::RSP_IDLE, 1'b1);
    wr(tdc_pkg::CMD_CODE_ADDR, 32'h0000_0002);
    rc(tdc_pkg::CMD_CODE_ADDR, 32'h0000_0002);
    rc(tdc_pkg::CMD_IN_ADDR, tdc_pkg::RSP_IDLE);
    chk(32'(nReq - k), 32'h0000_0001);
    wr(tdc_pkg::CMD_CODE_ADDR, tdc_pkg::CMD_NONE);
    rc(tdc_pkg::CMD_TARGET_ADDR, 32'h0000_0001);
    wr(12'h108, 32'hFFFF_FFFF);
    rc(12'h108, 32'h0000_0000);
    wr(12'h00C, 32'hFFFF_FFFF);
    rc(12'h00C, 32'h0000_0000);
    rc(12'h200, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    test_done();
  end
endmodule
`default_nettype wire
